// *** verilog/cpm_defines.svh ***
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
`define CPM_RESET_PC 32'h0000_0000
`define CPM_RESET_SR 16'h2700
`define CPM_SR_C 0
`define CPM_SR_V 1
`define CPM_SR_Z 2
`define CPM_SR_N 3
`define CPM_SR_X 4
`define CPM_SR_IPM_LO 8
`define CPM_SR_IPM_HI 10
`define CPM_SR_M 12
`define CPM_SR_S 13
`define CPM_SR_T0 14
`define CPM_SR_T1 15
`define CPM_SR_IMPL 16'hf71f
`define CPM_CCR_MASK 16'h001f
`define CPM_SP_SEL 3'h7
`define CPM_FC_UDATA 3'h1
`define CPM_FC_UPROG 3'h2
`define CPM_FC_SDATA 3'h5
`define CPM_FC_SPROG 3'h6
`define CPM_FC_CPU 3'h7
`define CPM_ICACHE_CONTROL_REG_IMPL 32'h0000_000f
`define CPM_ADDR24_MASK 32'h00ff_ffff
`endif

// *** verilog/cpm_pkg.sv ***
package cpm_pkg;
  typedef enum logic [3:0] {
    CPM_CR_SR, CPM_CR_CCR, CPM_CR_VBR, CPM_CR_SFC, CPM_CR_DFC,
    CPM_CR_ICACHE_CONTROL_REG, CPM_CR_ICACHE_ADDRESS_REG, CPM_CR_USP, CPM_CR_ISP, CPM_CR_MSP, CPM_CR_NONE
  } cpm_creg_t;
  typedef enum logic [1:0] {CPM_SZ_BYTE, CPM_SZ_WORD, CPM_SZ_LONG} cpm_size_t;
  typedef enum logic [1:0] {CPM_FCS_AUTO, CPM_FCS_SRC, CPM_FCS_DST, CPM_FCS_CPU} cpm_fcsel_t;
  typedef struct packed {
    logic en;
    logic [3:0] sel;
    cpm_size_t size;
    logic [31:0] data;
  } cpm_gpr_wr_t;
  typedef struct packed {
    logic en;
    cpm_creg_t sel;
    logic [31:0] data;
  } cpm_creg_wr_t;
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] base_offset;
    cpm_size_t base_offset_size;
    logic [3:0] index_sel;
    logic index_en;
    logic index_long;
    logic [1:0] scale;
    logic [31:0] outer_offset;
    cpm_size_t outer_offset_size;
  } cpm_ea_req_t;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpm_flags_t;
endpackage

// *** verilog/cpm_regs.sv ***
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "cpm_defines.svh"
module cpm_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // general register access
  input wire cpm_pkg::cpm_gpr_wr_t gpr_wr,
  input wire logic gpr_quad_wr,
  input wire logic [31:0] gpr_quad_hi,
  input wire logic [3:0] gpr_rd_sel,
  output logic [31:0] gpr_rd_data,
  output logic [31:0] gpr_rd_pair,
  // immediate operand
  input wire logic [31:0] imm_raw,
  input wire cpm_pkg::cpm_size_t imm_size,
  output logic [31:0] imm_value,
  // program counter
  input wire logic pc_inc,
  input wire logic [2:0] pc_inc_bytes,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_val,
  output logic [31:0] program_counter,
  // condition flags
  input wire logic flags_wr,
  input wire cpm_pkg::cpm_flags_t flags_in,
  output logic [15:0] processor_status_word,
  // control registers
  input wire cpm_pkg::cpm_creg_wr_t creg_wr,
  input wire cpm_pkg::cpm_creg_t creg_rd_sel,
  output logic [31:0] creg_rd_data,
  output logic privilege_violation,
  // exception entry
  input wire logic exc_enter,
  input wire logic [7:0] exc_vector,
  output logic [31:0] vector_address,
  // function codes
  input wire cpm_pkg::cpm_fcsel_t fc_sel,
  input wire logic fc_program,
  input wire logic addr24_mode,
  output logic [2:0] function_code,
  output logic [31:0] bus_address,
  // effective address
  input wire logic ea_start,
  input wire cpm_pkg::cpm_ea_req_t ea_req,
  input wire logic ea_indirect,
  input wire logic ea_preindex,
  input wire logic mem_ack,
  input wire logic [31:0] mem_data,
  output logic mem_req,
  output logic ea_done,
  output logic [31:0] ea_result,
  // cache control
  output logic [31:0] icache_control_reg,
  output logic [31:0] icache_address_reg
);
  import cpm_pkg::*;

  typedef enum {EA_IDLE, EA_FETCH, EA_OUTER} cpm_ea_st_t;

  function automatic logic [31:0] sext(input logic [31:0] v, input cpm_size_t s);
    case (s)
      CPM_SZ_BYTE: sext = {{24{v[7]}}, v[7:0]};
      CPM_SZ_WORD: sext = {{16{v[15]}}, v[15:0]};
      default: sext = v;
    endcase
  endfunction

  logic [31:0] data_regs [0:7];
  logic [31:0] address_regs [0:6];
  logic [31:0] user_stack_pointer;
  logic [31:0] interrupt_stack_pointer;
  logic [31:0] master_stack_pointer;
  logic [31:0] vector_table_base;
  logic [2:0] source_space_code;
  logic [2:0] destination_space_code;
  logic [15:0] sr_q;
  logic [31:0] pc_q;
  logic [31:0] icache_control_reg_q;
  logic [31:0] icache_address_reg_q;
  logic viol_q;
  cpm_ea_st_t ea_st_q;
  cpm_ea_st_t ea_st_d;
  logic [31:0] ea_acc_q;
  logic [31:0] ea_outer_q;
  logic [31:0] ea_res_q;
  logic [31:0] vaddr_q;
  logic [31:0] baddr_q;
  logic ea_index_late_q;
  logic ea_done_q;
  logic mem_req_q;
  logic [31:0] ea_index_q;
  logic [2:0] fc_q;
  logic [31:0] ea_acc_d;
  logic [31:0] ea_outer_d;
  logic [31:0] ea_index_d;
  logic [31:0] ea_res_d;
  logic ea_index_late_d;
  logic ea_done_d;
  logic mem_req_d;
  logic [31:0] gpr_old;
  logic [31:0] idx_raw;
  logic [31:0] creg_rd_d;

  wire sup = sr_q[`CPM_SR_S];
  wire master = sr_q[`CPM_SR_M];

  // stack pointer steering
  function automatic logic [31:0] gpr_read(input logic [3:0] s);
    if (!s[3])
      gpr_read = data_regs[s[2:0]];
    else if (s[2:0] != `CPM_SP_SEL)
      gpr_read = address_regs[s[2:0]];
    else if (!sup)
      gpr_read = user_stack_pointer;
    else if (master)
      gpr_read = master_stack_pointer;
    else
      gpr_read = interrupt_stack_pointer;
  endfunction

  // control register read, supervisor ones read zero at user level, except SR which reads its CCR bits
  function automatic logic [31:0] creg_read(input cpm_creg_t s);
    case (s)
      CPM_CR_SR: creg_read = sup ? {16'h0, sr_q} : {16'h0, sr_q & `CPM_CCR_MASK};
      CPM_CR_CCR: creg_read = {16'h0, sr_q & `CPM_CCR_MASK};
      CPM_CR_VBR: creg_read = sup ? vector_table_base : 32'h0;
      CPM_CR_SFC: creg_read = sup ? {29'h0, source_space_code} : 32'h0;
      CPM_CR_DFC: creg_read = sup ? {29'h0, destination_space_code} : 32'h0;
      CPM_CR_ICACHE_CONTROL_REG: creg_read = sup ? icache_control_reg_q : 32'h0;
      CPM_CR_ICACHE_ADDRESS_REG: creg_read = sup ? icache_address_reg_q : 32'h0;
      CPM_CR_USP: creg_read = sup ? user_stack_pointer : 32'h0;
      CPM_CR_ISP: creg_read = sup ? interrupt_stack_pointer : 32'h0;
      CPM_CR_MSP: creg_read = sup ? master_stack_pointer : 32'h0;
      default: creg_read = 32'h0;
    endcase
  endfunction

  // register reads, comb so array and mode changes are seen
  always_comb begin
    gpr_old = gpr_read(gpr_wr.sel);
    idx_raw = gpr_read(ea_req.index_sel);
    creg_rd_d = creg_read(creg_rd_sel);
  end

  // privileged write detection
  wire creg_priv = creg_wr.sel != CPM_CR_CCR && creg_wr.sel != CPM_CR_NONE;
  wire creg_ok = creg_wr.en && (sup || !creg_priv);
  wire creg_bad = creg_wr.en && !sup && creg_priv;
  wire [15:0] sr_wr_val = creg_wr.sel == CPM_CR_CCR ?
    ((sr_q & ~`CPM_CCR_MASK) | (creg_wr.data[15:0] & `CPM_CCR_MASK)) :
    (creg_wr.data[15:0] & `CPM_SR_IMPL);
  wire sr_creg_wr = creg_ok && (creg_wr.sel == CPM_CR_SR || creg_wr.sel == CPM_CR_CCR);

  // address register word writes sign-extend
  wire [31:0] gpr_val = gpr_wr.sel[3] ? sext(gpr_wr.data, gpr_wr.size == CPM_SZ_BYTE ?
    CPM_SZ_WORD : gpr_wr.size) : gpr_wr.data;
  wire [31:0] data_merge = gpr_wr.size == CPM_SZ_BYTE ? {gpr_old[31:8], gpr_wr.data[7:0]} :
    gpr_wr.size == CPM_SZ_WORD ? {gpr_old[31:16], gpr_wr.data[15:0]} : gpr_wr.data;
  wire [31:0] gpr_new = gpr_wr.sel[3] ? gpr_val : data_merge;
  wire [2:0] gpr_pair = gpr_wr.sel[2:0] + 3'h1;

  // ea index term
  wire [31:0] idx_ext = ea_req.index_long ? idx_raw : sext(idx_raw, CPM_SZ_WORD);
  wire [31:0] idx_scaled = ea_req.index_en ? (idx_ext << ea_req.scale) : 32'h0;
  wire [31:0] ea_first = ea_req.base + sext(ea_req.base_offset, ea_req.base_offset_size) +
    ((ea_indirect && !ea_preindex) ? 32'h0 : idx_scaled);
  wire [31:0] outer_ext = sext(ea_req.outer_offset, ea_req.outer_offset_size);

  // automatic function code
  wire [2:0] fc_auto = ea_st_q == EA_FETCH ? (sup ? `CPM_FC_SDATA : `CPM_FC_UDATA) :
    sup ? (fc_program ? `CPM_FC_SPROG : `CPM_FC_SDATA) :
    (fc_program ? `CPM_FC_UPROG : `CPM_FC_UDATA);
  wire [2:0] fc_next = fc_sel == CPM_FCS_SRC ? source_space_code :
    fc_sel == CPM_FCS_DST ? destination_space_code :
    fc_sel == CPM_FCS_CPU ? `CPM_FC_CPU : fc_auto;
  wire [31:0] addr_src = ea_st_q == EA_FETCH ? ea_acc_q : ea_res_q;
  wire [31:0] addr_next = addr24_mode ? (addr_src & `CPM_ADDR24_MASK) : addr_src;

  // general registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) data_regs[i] <= 32'h0;
      for (int i = 0; i < 7; i++) address_regs[i] <= 32'h0;
      user_stack_pointer <= 32'h0;
      interrupt_stack_pointer <= 32'h0;
      master_stack_pointer <= 32'h0;
    end else if (gpr_wr.en) begin
      if (!gpr_wr.sel[3]) begin
        data_regs[gpr_wr.sel[2:0]] <= gpr_new;
        if (gpr_quad_wr)
          data_regs[gpr_pair] <= gpr_quad_hi;
      end else if (gpr_wr.sel[2:0] != `CPM_SP_SEL)
        address_regs[gpr_wr.sel[2:0]] <= gpr_new;
      else if (!sup)
        user_stack_pointer <= gpr_new;
      else if (master)
        master_stack_pointer <= gpr_new;
      else
        interrupt_stack_pointer <= gpr_new;
    end else if (creg_ok) begin
      case (creg_wr.sel)
        CPM_CR_USP: user_stack_pointer <= creg_wr.data;
        CPM_CR_ISP: interrupt_stack_pointer <= creg_wr.data;
        CPM_CR_MSP: master_stack_pointer <= creg_wr.data;
        default: ;
      endcase
    end
  end

  // status word and control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      sr_q <= `CPM_RESET_SR;
      vector_table_base <= 32'h0;
      source_space_code <= 3'h0;
      destination_space_code <= 3'h0;
      icache_control_reg_q <= 32'h0;
      icache_address_reg_q <= 32'h0;
      viol_q <= 1'b0;
    end else begin
      viol_q <= creg_bad;
      if (sr_creg_wr)
        sr_q <= sr_wr_val;
      else if (exc_enter)
        sr_q <= sr_q | (16'h1 << `CPM_SR_S);
      else if (flags_wr)
        sr_q <= {sr_q[15:5], flags_in.x, flags_in.n, flags_in.z, flags_in.v,
          flags_in.c};
      if (creg_ok) begin
        case (creg_wr.sel)
          CPM_CR_VBR: vector_table_base <= creg_wr.data;
          CPM_CR_SFC: source_space_code <= creg_wr.data[2:0];
          CPM_CR_DFC: destination_space_code <= creg_wr.data[2:0];
          CPM_CR_ICACHE_CONTROL_REG: icache_control_reg_q <= creg_wr.data & `CPM_ICACHE_CONTROL_REG_IMPL;
          CPM_CR_ICACHE_ADDRESS_REG: icache_address_reg_q <= creg_wr.data;
          default: ;
        endcase
      end
    end
  end

  // program counter and vector address
  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_q <= `CPM_RESET_PC;
      vaddr_q <= 32'h0;
    end else begin
      if (pc_load)
        pc_q <= pc_load_val;
      else if (pc_inc)
        pc_q <= pc_q + {29'h0, pc_inc_bytes};
      if (exc_enter)
        vaddr_q <= vector_table_base + {22'h0, exc_vector, 2'h0};
    end
  end

  // effective address next state
  always_comb begin
    ea_st_d = ea_st_q;
    ea_acc_d = ea_acc_q;
    ea_outer_d = ea_outer_q;
    ea_index_d = ea_index_q;
    ea_index_late_d = ea_index_late_q;
    ea_res_d = ea_res_q;
    ea_done_d = 1'b0;
    mem_req_d = mem_req_q;
    case (ea_st_q)
      EA_IDLE: begin
        if (ea_start) begin
          ea_outer_d = outer_ext;
          ea_index_d = idx_scaled;
          ea_index_late_d = !ea_preindex;
          if (ea_indirect) begin
            ea_acc_d = ea_first;
            mem_req_d = 1'b1;
            ea_st_d = EA_FETCH;
          end else begin
            ea_res_d = ea_first;
            ea_done_d = 1'b1;
          end
        end
      end
      EA_FETCH: begin
        if (mem_ack) begin
          mem_req_d = 1'b0;
          ea_acc_d = mem_data + (ea_index_late_q ? ea_index_q : 32'h0);
          ea_st_d = EA_OUTER;
        end
      end
      EA_OUTER: begin
        ea_res_d = ea_acc_q + ea_outer_q;
        ea_done_d = 1'b1;
        ea_st_d = EA_IDLE;
      end
      default: ea_st_d = EA_IDLE;
    endcase
  end

  // effective address sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      ea_st_q <= EA_IDLE;
      ea_acc_q <= 32'h0;
      ea_outer_q <= 32'h0;
      ea_index_q <= 32'h0;
      ea_index_late_q <= 1'b0;
      ea_res_q <= 32'h0;
      ea_done_q <= 1'b0;
      mem_req_q <= 1'b0;
    end else begin
      ea_st_q <= ea_st_d;
      ea_acc_q <= ea_acc_d;
      ea_outer_q <= ea_outer_d;
      ea_index_q <= ea_index_d;
      ea_index_late_q <= ea_index_late_d;
      ea_res_q <= ea_res_d;
      ea_done_q <= ea_done_d;
      mem_req_q <= mem_req_d;
    end
  end

  // output registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      fc_q <= 3'h0;
      baddr_q <= 32'h0;
      gpr_rd_data <= 32'h0;
      gpr_rd_pair <= 32'h0;
      creg_rd_data <= 32'h0;
      imm_value <= 32'h0;
    end else begin
      fc_q <= fc_next;
      baddr_q <= addr_next;
      gpr_rd_data <= gpr_read(gpr_rd_sel);
      gpr_rd_pair <= data_regs[gpr_rd_sel[2:0] + 3'h1];
      imm_value <= sext(imm_raw, imm_size);
      creg_rd_data <= creg_rd_d;
    end
  end

  assign program_counter = pc_q;
  assign processor_status_word = sr_q;
  assign privilege_violation = viol_q;
  assign vector_address = vaddr_q;
  assign function_code = fc_q;
  assign bus_address = baddr_q;
  assign mem_req = mem_req_q;
  assign ea_done = ea_done_q;
  assign ea_result = ea_res_q;
  assign icache_control_reg = icache_control_reg_q;
  assign icache_address_reg = icache_address_reg_q;
endmodule // cpm_regs

// *** tb/cpm_regs_checker.sv ***
`timescale 1ns/100ps
`include "cpm_defines.svh"
module cpm_regs_checker
  import cpm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // program counter
  input wire logic pc_inc,
  input wire logic [2:0] pc_inc_bytes,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_val,
  input wire logic [31:0] program_counter,
  // status and control
  input wire logic flags_wr,
  input wire cpm_pkg::cpm_flags_t flags_in,
  input wire logic [15:0] processor_status_word,
  input wire cpm_pkg::cpm_creg_wr_t creg_wr,
  input wire logic privilege_violation,
  input wire logic exc_enter,
  // operands and spaces
  input wire cpm_pkg::cpm_fcsel_t fc_sel,
  input wire logic [2:0] function_code,
  input wire logic [31:0] imm_raw,
  input wire cpm_pkg::cpm_size_t imm_size,
  input wire logic [31:0] imm_value,
  // effective address
  input wire logic ea_start,
  input wire logic ea_indirect,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic ea_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  pc_step_a: assert property (pc_inc && !pc_load |=>
    program_counter == $past(program_counter) + $past(pc_inc_bytes)) else $error("pc step");
  pc_load_a: assert property (pc_load |=>
    program_counter == $past(pc_load_val)) else $error("pc load");
  flag_upd_a: assert property (flags_wr && !creg_wr.en && !exc_enter |=>
    processor_status_word[4:0] == $past(flags_in)) else $error("flags");
  sr_bits_a: assert property (
    (processor_status_word & ~`CPM_SR_IMPL) == 16'h0) else $error("sr bits");
  user_wr_a: assert property (creg_wr.en && !processor_status_word[13] &&
    !(creg_wr.sel inside {CPM_CR_CCR, CPM_CR_NONE}) |=> privilege_violation) else $error("viol");
  viol_src_a: assert property (privilege_violation |->
    $past(creg_wr.en) && !$past(processor_status_word[13])) else $error("viol cause");
  exc_sup_a: assert property (exc_enter |=> processor_status_word[13]) else $error("exc s");
  fc_cpu_a: assert property (fc_sel == CPM_FCS_CPU |=>
    function_code == `CPM_FC_CPU) else $error("fc cpu");
  imm_word_a: assert property (imm_size == CPM_SZ_WORD |=>
    imm_value == {{16{$past(imm_raw[15])}}, $past(imm_raw[15:0])}) else $error("imm");
  ea_direct_a: assert property (ea_start && !ea_indirect |=> ea_done) else $error("ea");
  ind_req_a: assert property (ea_start && ea_indirect |=> mem_req && !ea_done)
    else $error("ind req");
  ind_done_a: assert property (mem_req && mem_ack |=> !mem_req ##1 ea_done)
    else $error("ind done");
endmodule // cpm_regs_checker
bind cpm_regs cpm_regs_checker i_chk (.*);

// *** tb/cpm_mem_model.sv ***
`timescale 1ns/100ps
module cpm_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pointer fetch
  input wire logic mem_req,
  input wire logic [31:0] bus_address,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_data
);
  logic [3:0] wait_q;
  logic done_q;
  always_ff @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_data <= ~mem_data;
    if (reset || !mem_req) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q && wait_q == lat + 4'h1) begin
      mem_ack <= 1'b1;
      done_q <= 1'b1;
      mem_data <= bus_address ^ 32'h5a5a_0000;
    end else if (!done_q) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // cpm_mem_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import cpm_pkg::*;
  logic mclk, reset, gpr_quad_wr, pc_inc, pc_load, flags_wr, exc_enter, fc_program;
  logic addr24_mode, ea_start, ea_indirect, ea_preindex, mem_ack, mem_req, ea_done;
  logic privilege_violation;
  logic [2:0] pc_inc_bytes, function_code;
  logic [3:0] gpr_rd_sel, lat;
  logic [7:0] exc_vector;
  logic [15:0] processor_status_word;
  logic [31:0] gpr_quad_hi, gpr_rd_data, gpr_rd_pair, imm_raw, imm_value, pc_load_val;
  logic [31:0] program_counter, creg_rd_data, vector_address, bus_address, mem_data;
  logic [31:0] ea_result, icache_control_reg, icache_address_reg;
  cpm_gpr_wr_t gpr_wr;
  cpm_size_t imm_size;
  cpm_flags_t flags_in;
  cpm_creg_wr_t creg_wr;
  cpm_creg_t creg_rd_sel;
  cpm_fcsel_t fc_sel;
  cpm_ea_req_t ea_req;
  int error_cnt, num_checks, n;
  logic [31:0] imm_exp [0:2] = '{32'hffff_ff80, 32'hffff_8080, 32'h1234_8080};
  cpm_regs i_dut (.*);
  cpm_mem_model i_mem (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cw(input cpm_creg_t s, input logic [31:0] d);
    @(posedge mclk) creg_wr <= '{1'b1, s, d};
    @(posedge mclk) creg_wr.en <= 1'b0;
    #1;
  endtask
  task automatic cr(input cpm_creg_t s, input logic [31:0] e);
    @(posedge mclk) creg_rd_sel <= s;
    @(posedge mclk) #1 chk(creg_rd_data, e);
  endtask
  task automatic gw(input logic [3:0] s, input cpm_size_t z, input logic [31:0] d, input logic q);
    @(posedge mclk) gpr_wr <= '{1'b1, s, z, d};
    gpr_quad_wr <= q;
    @(posedge mclk) gpr_wr.en <= 1'b0;
    gpr_quad_wr <= 1'b0;
  endtask
  task automatic gr(input logic [3:0] s, input logic [31:0] e);
    @(posedge mclk) gpr_rd_sel <= s;
    @(posedge mclk) #1 chk(gpr_rd_data, e);
  endtask
  task automatic fc(input cpm_fcsel_t s, input logic p, input logic [2:0] e);
    @(posedge mclk) fc_sel <= s;
    fc_program <= p;
    @(posedge mclk) #1 chk(32'(function_code), 32'(e));
  endtask
  task automatic ea(input logic i, input logic p, input logic [31:0] o, input logic [31:0] e);
    @(posedge mclk) ea_start <= 1'b1;
    ea_indirect <= i;
    ea_preindex <= p;
    ea_req.outer_offset <= o;
    @(posedge mclk) ea_start <= 1'b0;
    #1 n = 0;
    while (ea_done !== 1'b1 && n < 20) begin
      @(posedge mclk) #1 n++;
    end
    chk(ea_result, e);
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    {gpr_quad_wr, pc_inc, pc_load, flags_wr, exc_enter, fc_program} = '0;
    {addr24_mode, ea_start, ea_indirect, ea_preindex} = '0;
    {pc_inc_bytes, gpr_rd_sel, lat, exc_vector, imm_raw, pc_load_val} = '0;
    gpr_quad_hi = 32'h600d_0001;
    gpr_wr = '0;
    creg_wr = '0;
    flags_in = '0;
    imm_size = CPM_SZ_BYTE;
    creg_rd_sel = CPM_CR_NONE;
    fc_sel = CPM_FCS_AUTO;
    ea_req = '{base: 32'h1000, base_offset: 32'hfff0, base_offset_size: CPM_SZ_WORD,
      index_sel: 4'h2, index_en: 1'b1, index_long: 1'b0, scale: 2'h3,
      outer_offset: 32'h0, outer_offset_size: CPM_SZ_WORD};
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    #1 chk(32'(processor_status_word), 32'h2700);
    @(posedge mclk) pc_inc <= 1'b1;
    pc_inc_bytes <= 3'h4;
    @(posedge mclk) pc_load <= 1'b1;
    pc_load_val <= 32'h100;
    #1 chk(program_counter, 32'h4);
    @(posedge mclk) {pc_inc, pc_load} <= 2'b00;
    #1 chk(program_counter, 32'h100);
    @(posedge mclk) flags_wr <= 1'b1;
    flags_in <= cpm_flags_t'(5'h15);
    @(posedge mclk) flags_wr <= 1'b0;
    #1 chk(32'(processor_status_word), 32'h2715);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) imm_size <= cpm_size_t'(i);
      imm_raw <= 32'h1234_8080;
      @(posedge mclk) #1 chk(imm_value, imm_exp[i]);
    end
    gw(4'h2, CPM_SZ_LONG, 32'h0001_0003, 1'b0);
    gw(4'h3, CPM_SZ_LONG, 32'haaaa_aaaa, 1'b0);
    gw(4'h3, CPM_SZ_BYTE, 32'hff, 1'b0);
    gr(4'h3, 32'haaaa_aaff);
    gw(4'h9, CPM_SZ_WORD, 32'h8000, 1'b0);
    gr(4'h9, 32'hffff_8000);
    gw(4'h7, CPM_SZ_LONG, 32'h7, 1'b1);
    gr(4'h7, 32'h7);
    chk(gpr_rd_pair, 32'h600d_0001);
    cw(CPM_CR_VBR, 32'h400);
    cw(CPM_CR_SFC, 32'h3);
    cw(CPM_CR_DFC, 32'h4);
    cw(CPM_CR_ICACHE_CONTROL_REG, 32'hffff_ffff);
    cw(CPM_CR_ICACHE_ADDRESS_REG, 32'h1234_5678);
    chk(icache_control_reg, 32'hf);
    chk(icache_address_reg, 32'h1234_5678);
    gw(4'hf, CPM_SZ_LONG, 32'h4000, 1'b0);
    cr(CPM_CR_ISP, 32'h4000);
    fc(CPM_FCS_SRC, 1'b0, 3'h3);
    fc(CPM_FCS_DST, 1'b0, 3'h4);
    fc(CPM_FCS_CPU, 1'b0, 3'h7);
    fc(CPM_FCS_AUTO, 1'b1, 3'h6);
    fc(CPM_FCS_AUTO, 1'b0, 3'h5);
    ea(1'b0, 1'b0, 32'h0, 32'h1008);
    for (int p = 0; p < 2; p++) begin
      lat = 4'(p * 3);
      ea(1'b1, 1'(p), 32'hff00, 32'h5a5a_0f08);
    end
    @(posedge mclk) addr24_mode <= 1'b1;
    #1 chk(bus_address, 32'h5a5a_0f08);
    @(posedge mclk) addr24_mode <= 1'b0;
    #1 chk(bus_address, 32'h005a_0f08);
    @(posedge mclk) ea_req.base_offset_size <= CPM_SZ_BYTE;
    ea_req.base_offset <= 32'h0000_0180;
    ea(1'b0, 1'b0, 32'h0, 32'h0000_0f98);
    cw(CPM_CR_SR, 32'h0713);
    cr(CPM_CR_SR, 32'h13);
    fc(CPM_FCS_AUTO, 1'b1, 3'h2);
    fc(CPM_FCS_AUTO, 1'b0, 3'h1);
    gw(4'hf, CPM_SZ_LONG, 32'h5000, 1'b0);
    gr(4'hf, 32'h5000);
    cr(CPM_CR_ISP, 32'h0);
    cw(CPM_CR_VBR, 32'h800);
    chk(32'(privilege_violation), 32'h1);
    @(posedge mclk) exc_enter <= 1'b1;
    exc_vector <= 8'h02;
    @(posedge mclk) exc_enter <= 1'b0;
    #1 chk(vector_address, 32'h408);
    cr(CPM_CR_VBR, 32'h400);
    cr(CPM_CR_SR, 32'h2713);
    cw(CPM_CR_SR, 32'h3700);
    gw(4'hf, CPM_SZ_LONG, 32'h6000, 1'b0);
    cr(CPM_CR_MSP, 32'h6000);
    gr(4'hf, 32'h6000);
    cr(CPM_CR_ISP, 32'h4000);
    summarize();
  end
endmodule // testbench
